// File: hw/mcm_regs.svh
// Constants of the multiport core memory unit: widths, timing, register map.
// Assumes inclusion by every file that uses these names; the guard stops repeats.
`ifndef MCM_REGS_SVH
`define MCM_REGS_SVH
`define MCM_NPORT        12
`define MCM_NPORT_MIN    2
`define MCM_PW           4
`define MCM_NBANK        2
`define MCM_AW           22
`define MCM_BW           14
`define MCM_DW           32
`define MCM_LANES        4
`define MCM_BYTE         8
`define MCM_BE_ALL       4'hF
`define MCM_G32_LSB      15
`define MCM_G64_LSB      16
`define MCM_ILV_ABIT     0
`define MCM_SLOT_ABIT    1
`define MCM_CLK_MHZ      200
`define MCM_T_FULL_NS    900
`define MCM_T_PART_NS    1060
`define MCM_CYC_FULL     ((`MCM_T_FULL_NS * `MCM_CLK_MHZ + 999) / 1000)
`define MCM_CYC_PART     ((`MCM_T_PART_NS * `MCM_CLK_MHZ + 999) / 1000)
`define MCM_CNT_W        8
`define MCM_REG_CTRL     5'h00
`define MCM_REG_BASE     5'h04
`define MCM_REG_STATUS   5'h08
`define MCM_REG_MASK     5'h0C
`define MCM_REG_PORTS    5'h10
`define MCM_REG_SNAP0    5'h14
`define MCM_REG_SNAP1    5'h18
`define MCM_REG_SNAP2    5'h1C
`define MCM_CTRL_ILV_LSB 0
`define MCM_CTRL_SLOT    2
`define MCM_CTRL_INJ     3
`define MCM_CTRL_UNIT    4
`define MCM_CTRL_BUSY    8
`define MCM_CTRL_WMASK   32'h0000_00FF
`define MCM_CTRL_RST     32'h0000_0001
`define MCM_BASE_WMASK   32'h003F_8000
`define MCM_PORTS_RST    4'hC
`define MCM_ST_CPU_ERR   0
`define MCM_ST_IOP_ERR   1
`define MCM_ST_HIPRI     2
`define MCM_ST_W         3
`define MCM_SNAP_WORDS   3
`define MCM_SN_FLT_LSB   0
`define MCM_SN_PORT_LSB  8
`define MCM_SN_ILV_LSB   0
`define MCM_SN_SIZE_LSB  8
`define MCM_SN_BANK      16
`define MCM_FLT_READ     4'h1
`define MCM_FLT_PART     4'h2
`define MCM_BANK_K       8'h10
`define MCM_UNIT_K       8'h20
`endif

// File: hw/mcm_pkg.sv
// Types shared by the memory unit top, its banks and its arbiters.
// Assumes the register header is on the include path.
`include "mcm_regs.svh"
package mcm_pkg;
   typedef enum logic [1:0] {
      MCM_SZ_BYTE = 2'h0,
      MCM_SZ_HALF = 2'h1,
      MCM_SZ_WORD = 2'h2
   } mcm_size_t;
   typedef enum logic [1:0] {
      MCM_ILV_NONE = 2'h0,
      MCM_ILV_MOD2 = 2'h1,
      MCM_ILV_MOD4 = 2'h2
   } mcm_ilv_t;
   typedef enum logic [1:0] {
      MCM_BS_IDLE = 2'b00,
      MCM_BS_BUSY = 2'b01,
      MCM_BS_DONE = 2'b11
   } mcm_bst_t;
   typedef struct packed {
      mcm_bst_t                              st;
      logic [`MCM_CNT_W-1:0]                 cnt;
      logic                                  wr;
      logic [`MCM_LANES-1:0]                 be;
      logic [`MCM_BW-1:0]                    idx;
      logic [`MCM_DW-1:0]                    wd;
      logic                                  inj;
      logic [`MCM_DW-1:0]                    rd;
      logic                                  perr;
      logic [(1<<`MCM_BW)-1:0][`MCM_DW:0]    mem;
   } mcm_bank_st_t;
   typedef struct packed {
      logic                                  wt;
      logic [`MCM_DW-1:0]                    rdat;
      logic [`MCM_DW-1:0]                    ctrl;
      logic [`MCM_DW-1:0]                    base;
      logic [`MCM_ST_W-1:0]                  status;
      logic [`MCM_ST_W-1:0]                  mask;
      logic [`MCM_PW-1:0]                    ports;
      logic [`MCM_SNAP_WORDS-1:0][`MCM_DW-1:0] snap;
      logic                                  irq;
      logic [`MCM_NPORT-1:0]                 ack;
      logic [`MCM_NPORT-1:0]                 trap;
      logic [`MCM_NPORT-1:0][`MCM_DW-1:0]    prd;
      logic [`MCM_NBANK-1:0]                 start;
      logic [`MCM_NBANK-1:0][`MCM_PW-1:0]    own;
      logic [`MCM_NBANK-1:0]                 op_wr;
      logic [`MCM_NBANK-1:0][`MCM_LANES-1:0] op_be;
      logic [`MCM_NBANK-1:0][`MCM_BW-1:0]    op_idx;
      logic [`MCM_NBANK-1:0][`MCM_DW-1:0]    op_wd;
      logic [`MCM_NBANK-1:0][1:0]            op_size;
      logic [`MCM_NBANK-1:0][1:0]            op_boff;
      logic [`MCM_NBANK-1:0]                 op_snap;
      logic [`MCM_NBANK-1:0][1:0]            op_sidx;
      logic [`MCM_NBANK-1:0]                 op_cpu;
   } mcm_top_st_t;
endpackage : mcm_pkg

// File: hw/mcm_arb.sv
// Per-bank port arbiter, purely combinational.
// Assumes the caller has already masked ports that may not take this bank.
`timescale 1ns/100ps
`include "mcm_regs.svh"
module mcm_arb
   import mcm_pkg::*;
(
   input  wire logic [`MCM_NPORT-1:0] req,
   input  wire logic [`MCM_NPORT-1:0] hipri,
   output      logic                  any,
   output      logic [`MCM_PW-1:0]    idx
);
   logic [`MCM_NPORT-1:0] pool;

   always_comb begin
      pool = (|(req & hipri)) ? (req & hipri) : req;
      any  = |pool;
      idx  = '0;
      for (int i = `MCM_NPORT - 1; i >= 0; i--) begin
         if (pool[i]) begin
            idx = `MCM_PW'(i);
         end
      end
   end
endmodule : mcm_arb

// File: hw/mcm_bank.sv
// One 16K-word core bank with parity, fixed access timing and read-modify-write.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/100ps
`include "mcm_regs.svh"
module mcm_bank
   import mcm_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  start,
   input  wire logic                  write,
   input  wire logic [`MCM_LANES-1:0] be,
   input  wire logic [`MCM_BW-1:0]    index,
   input  wire logic [`MCM_DW-1:0]    wdata,
   input  wire logic                  inject,
   output      logic                  busy,
   output      logic                  done,
   output      logic [`MCM_DW-1:0]    rdata,
   output      logic                  perr
);
   mcm_bank_st_t        q;
   mcm_bank_st_t        d;
   logic [`MCM_DW:0]    old;
   logic [`MCM_DW-1:0]  merged;
   logic                part;

   assign old  = q.mem[q.idx];
   assign part = write && (be != `MCM_BE_ALL);

   for (genvar i = 0; i < `MCM_LANES; i++) begin : g_lane
      assign merged[i*`MCM_BYTE +: `MCM_BYTE] =
         q.be[i] ? q.wd[i*`MCM_BYTE +: `MCM_BYTE] : old[i*`MCM_BYTE +: `MCM_BYTE];
   end

   always_comb begin
      d = q;
      case (q.st)
         MCM_BS_IDLE: begin
            if (start) begin
               d.st  = MCM_BS_BUSY;
               d.wr  = write;
               d.be  = be;
               d.idx = index;
               d.wd  = wdata;
               d.inj = inject;
               d.cnt = part ? `MCM_CNT_W'(`MCM_CYC_PART - 1)
                            : `MCM_CNT_W'(`MCM_CYC_FULL - 1);
            end
         end
         MCM_BS_BUSY: begin
            if (q.cnt == '0) begin
               d.st   = MCM_BS_DONE;
               d.rd   = old[`MCM_DW-1:0];
               // Full writes never check the parity of the old word
               d.perr = (!q.wr || q.be != `MCM_BE_ALL) && (^old);
               if (q.wr) begin
                  d.mem[q.idx] = {(^merged) ^ q.inj, merged};
               end
            end else begin
               d.cnt = q.cnt - 1'b1;
            end
         end
         MCM_BS_DONE: d.st = MCM_BS_IDLE;
         default:     d.st = MCM_BS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy  = q.st != MCM_BS_IDLE;
   assign done  = q.st == MCM_BS_DONE;
   assign rdata = q.rd;
   assign perr  = q.perr && done;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_done_pulse: assert property (
      done |=> !done && !busy)
      else $error("bank done longer than one cycle");
endmodule : mcm_bank

// File: hw/mcm_unit.sv
// Top of one 32K-word core memory unit: port decode, per-bank arbitration,
// diagnostic snapshot and an Avalon-MM register slave with waitrequest.
// Assumes each port holds its request until it sees its ack pulse.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "mcm_regs.svh"
module mcm_unit
   import mcm_pkg::*;
(
   input  wire logic                              clk_sys,
   input  wire logic                              rst_n,
   input  wire logic [4:0]                        avs_address,
   input  wire logic                              avs_read,
   input  wire logic                              avs_write,
   input  wire logic [`MCM_DW-1:0]                avs_writedata,
   input  wire logic [`MCM_LANES-1:0]             avs_byteenable,
   output      logic [`MCM_DW-1:0]                avs_readdata,
   output      logic                              avs_waitrequest,
   output      logic                              irq,
   input  wire logic [`MCM_NPORT-1:0]             port_req,
   input  wire logic [`MCM_NPORT-1:0]             port_hipri,
   input  wire logic [`MCM_NPORT-1:0]             port_cpu,
   input  wire logic [`MCM_NPORT-1:0]             port_write,
   input  wire logic [`MCM_NPORT-1:0]             port_diag,
   input  wire logic [`MCM_NPORT-1:0]             port_snap,
   input  wire logic [`MCM_NPORT-1:0][1:0]        port_size,
   input  wire logic [`MCM_NPORT-1:0][1:0]        port_boff,
   input  wire logic [`MCM_NPORT-1:0][`MCM_AW-1:0] port_addr,
   input  wire logic [`MCM_NPORT-1:0][`MCM_DW-1:0] port_wdata,
   output      logic [`MCM_NPORT-1:0]             port_ack,
   output      logic [`MCM_NPORT-1:0][`MCM_DW-1:0] port_rdata,
   output      logic [`MCM_NPORT-1:0]             port_trap
);
   localparam int A_FULL = `MCM_CYC_FULL + 1;
   localparam int A_PART = `MCM_CYC_PART + 1;

   mcm_top_st_t                        q;
   mcm_top_st_t                        d;
   mcm_ilv_t                           ilv;
   logic [`MCM_NPORT-1:0]              hit;
   logic [`MCM_NPORT-1:0]              bsel;
   logic [`MCM_NPORT-1:0][`MCM_BW-1:0] widx;
   logic [`MCM_NBANK-1:0][`MCM_NPORT-1:0] elig;
   logic [`MCM_NBANK-1:0]              arb_any;
   logic [`MCM_NBANK-1:0][`MCM_PW-1:0] arb_idx;
   logic [`MCM_NBANK-1:0]              gnt;
   logic [`MCM_NBANK-1:0]              bk_busy;
   logic [`MCM_NBANK-1:0]              bk_done;
   logic [`MCM_NBANK-1:0]              bk_perr;
   logic [`MCM_NBANK-1:0][`MCM_DW-1:0] bk_rdata;
   logic [`MCM_DW-1:0]                 bmask;
   logic [`MCM_DW-1:0]                 rmux;
   logic [`MCM_ST_W-1:0]               ev;
   logic [`MCM_ST_W-1:0]               clr;
   logic [`MCM_PW-1:0]                 gp;
   logic [`MCM_PW-1:0]                 pv;
   logic [`MCM_DW-1:0]                 dw;

   function automatic logic [`MCM_LANES-1:0] lane_be(logic [1:0] s, logic [1:0] o);
      case (mcm_size_t'(s))
         MCM_SZ_BYTE: lane_be = 4'h1 << o;
         MCM_SZ_HALF: lane_be = 4'h3 << {o[1], 1'b0};
         default:     lane_be = `MCM_BE_ALL;
      endcase
   endfunction : lane_be

   function automatic logic [`MCM_DW-1:0] lane_wd(logic [1:0] s, logic [`MCM_DW-1:0] w);
      case (mcm_size_t'(s))
         MCM_SZ_BYTE: lane_wd = {4{w[7:0]}};
         MCM_SZ_HALF: lane_wd = {2{w[15:0]}};
         default:     lane_wd = w;
      endcase
   endfunction : lane_wd

   function automatic logic [`MCM_DW-1:0] pick(logic [1:0] s, logic [1:0] o,
                                                 logic [`MCM_DW-1:0] w);
      case (mcm_size_t'(s))
         MCM_SZ_BYTE: pick = {24'h0, w[{o, 3'h0} +: 8]};
         MCM_SZ_HALF: pick = {16'h0, w[{o[1], 4'h0} +: 16]};
         default:     pick = w;
      endcase
   endfunction : pick

   function automatic logic [`MCM_NPORT-1:0] below(logic [`MCM_PW-1:0] i);
      below = (`MCM_NPORT'(1) << i) - `MCM_NPORT'(1);
   endfunction : below

   assign ilv = mcm_ilv_t'(q.ctrl[`MCM_CTRL_ILV_LSB +: 2]);

   // Address decode per port
   for (genvar p = 0; p < `MCM_NPORT; p++) begin : g_port
      logic [`MCM_AW-1:0] a;
      assign a = port_addr[p];
      always_comb begin
         case (ilv)
            MCM_ILV_MOD4: begin
               hit[p]  = a[`MCM_AW-1:`MCM_G64_LSB] == q.base[`MCM_AW-1:`MCM_G64_LSB]
                         && a[`MCM_SLOT_ABIT] == q.ctrl[`MCM_CTRL_SLOT];
               bsel[p] = a[`MCM_ILV_ABIT];
               widx[p] = a[`MCM_G64_LSB-1 -: `MCM_BW];
            end
            MCM_ILV_MOD2: begin
               hit[p]  = a[`MCM_AW-1:`MCM_G32_LSB] == q.base[`MCM_AW-1:`MCM_G32_LSB];
               bsel[p] = a[`MCM_ILV_ABIT];
               widx[p] = a[`MCM_G32_LSB-1 -: `MCM_BW];
            end
            default: begin
               hit[p]  = a[`MCM_AW-1:`MCM_G32_LSB] == q.base[`MCM_AW-1:`MCM_G32_LSB];
               bsel[p] = a[`MCM_BW];
               widx[p] = a[`MCM_BW-1:0];
            end
         endcase
      end
   end

   // One arbiter and one bank each; banks run concurrently
   for (genvar b = 0; b < `MCM_NBANK; b++) begin : g_bank
      for (genvar p = 0; p < `MCM_NPORT; p++) begin : g_elig
         assign elig[b][p] = port_req[p] && hit[p] && (bsel[p] == b)
                             && (p < q.ports) && !q.ack[p];
      end
      assign gnt[b] = arb_any[b] && !bk_busy[b] && !q.start[b];

      mcm_arb u_arb (
         .req   (elig[b]),
         .hipri (port_hipri),
         .any   (arb_any[b]),
         .idx   (arb_idx[b])
      );

      mcm_bank u_bank (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .start   (q.start[b]),
         .write   (q.op_wr[b]),
         .be      (q.op_be[b]),
         .index   (q.op_idx[b]),
         .wdata   (q.op_wd[b]),
         .inject  (q.ctrl[`MCM_CTRL_INJ]),
         .busy    (bk_busy[b]),
         .done    (bk_done[b]),
         .rdata   (bk_rdata[b]),
         .perr    (bk_perr[b])
      );
   end

   for (genvar i = 0; i < `MCM_LANES; i++) begin : g_bmask
      assign bmask[i*`MCM_BYTE +: `MCM_BYTE] = {`MCM_BYTE{avs_byteenable[i]}};
   end

   always_comb begin
      case (avs_address)
         `MCM_REG_CTRL:   rmux = q.ctrl | (`MCM_DW'(bk_busy) << `MCM_CTRL_BUSY);
         `MCM_REG_BASE:   rmux = q.base;
         `MCM_REG_STATUS: rmux = `MCM_DW'(q.status);
         `MCM_REG_MASK:   rmux = `MCM_DW'(q.mask);
         `MCM_REG_PORTS:  rmux = `MCM_DW'(q.ports);
         `MCM_REG_SNAP0:  rmux = q.snap[0];
         `MCM_REG_SNAP1:  rmux = q.snap[1];
         `MCM_REG_SNAP2:  rmux = q.snap[2];
         default:         rmux = '0;
      endcase
   end

   always_comb begin
      d       = q;
      d.ack   = '0;
      d.trap  = '0;
      d.start = '0;
      ev      = '0;
      clr     = '0;
      gp      = '0;
      dw      = '0;
      pv      = avs_writedata[`MCM_PW-1:0];
      // One wait cycle, then a one-cycle answer
      if ((avs_read || avs_write) && q.wt) begin
         d.wt   = 1'b0;
         d.rdat = avs_read ? rmux : '0;
      end else begin
         d.wt = 1'b1;
      end
      if (!q.wt && avs_write) begin
         case (avs_address)
            `MCM_REG_CTRL: begin
               d.ctrl = (q.ctrl & ~(bmask & `MCM_CTRL_WMASK))
                        | (avs_writedata & bmask & `MCM_CTRL_WMASK);
            end
            `MCM_REG_BASE: begin
               d.base = (q.base & ~(bmask & `MCM_BASE_WMASK))
                        | (avs_writedata & bmask & `MCM_BASE_WMASK);
            end
            `MCM_REG_MASK: begin
               if (avs_byteenable[0]) begin
                  d.mask = avs_writedata[`MCM_ST_W-1:0];
               end
            end
            `MCM_REG_PORTS: begin
               if (avs_byteenable[0]) begin
                  d.ports = (pv < `MCM_PW'(`MCM_NPORT_MIN)) ? `MCM_PW'(`MCM_NPORT_MIN) :
                            (pv > `MCM_PW'(`MCM_NPORT)) ? `MCM_PW'(`MCM_NPORT) : pv;
               end
            end
            default: ;
         endcase
      end
      if (!q.wt && avs_read && avs_address == `MCM_REG_STATUS) begin
         clr = q.rdat[`MCM_ST_W-1:0];
      end
      for (int b = 0; b < `MCM_NBANK; b++) begin
         if (gnt[b]) begin
            gp            = arb_idx[b];
            d.start[b]    = 1'b1;
            d.own[b]      = gp;
            d.op_cpu[b]   = port_cpu[gp];
            d.op_snap[b]  = port_cpu[gp] && port_diag[gp] && port_snap[gp];
            d.op_wr[b]    = port_write[gp] && !d.op_snap[b];
            d.op_be[b]    = lane_be(port_size[gp], port_boff[gp]);
            d.op_wd[b]    = lane_wd(port_size[gp], port_wdata[gp]);
            d.op_idx[b]   = widx[gp];
            d.op_size[b]  = port_size[gp];
            d.op_boff[b]  = port_boff[gp];
            d.op_sidx[b]  = port_addr[gp][1:0];
            if (port_hipri[gp] && (elig[b] & below(gp)) != '0) begin
               ev[`MCM_ST_HIPRI] = 1'b1;
            end
         end
         if (bk_done[b]) begin
            gp = q.own[b];
            if (!q.op_snap[b]) begin
               dw = bk_rdata[b];
            end else if (q.op_sidx[b] < 2'(`MCM_SNAP_WORDS)) begin
               dw = q.snap[q.op_sidx[b]];
            end
            d.prd[gp] = pick(q.op_size[b], q.op_boff[b], dw);
            d.ack[gp] = 1'b1;
            if (bk_perr[b] && !q.op_snap[b]) begin
               d.trap[gp] = q.op_cpu[b];
               if (q.op_cpu[b]) begin
                  ev[`MCM_ST_CPU_ERR] = 1'b1;
               end else begin
                  ev[`MCM_ST_IOP_ERR] = 1'b1;
               end
               d.snap = '0;
               d.snap[0][`MCM_SN_FLT_LSB +: 4]  = q.op_wr[b] ? `MCM_FLT_PART : `MCM_FLT_READ;
               d.snap[0][`MCM_SN_PORT_LSB +: 4] = gp + 4'h1;
               d.snap[1][`MCM_SN_ILV_LSB +: 2]  = ilv;
               d.snap[1][`MCM_SN_SIZE_LSB +: 8] = `MCM_BANK_K;
               d.snap[1][`MCM_SN_BANK]          = 1'(b);
               d.snap[2][`MCM_SN_FLT_LSB +: 4]  = q.ctrl[`MCM_CTRL_UNIT +: 4];
               d.snap[2][`MCM_SN_SIZE_LSB +: 8] = `MCM_UNIT_K;
            end
         end
      end
      // New events win over a read-clear in the same cycle
      d.status = (q.status & ~clr) | ev;
      d.irq    = |(d.status & d.mask);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q       <= '0;
         q.wt    <= 1'b1;
         q.ctrl  <= `MCM_CTRL_RST;
         q.ports <= `MCM_PORTS_RST;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata    = q.rdat;
   assign avs_waitrequest = q.wt;
   assign irq             = q.irq;
   assign port_ack        = q.ack;
   assign port_rdata      = q.prd;
   assign port_trap       = q.trap;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   for (genvar b = 0; b < `MCM_NBANK; b++) begin : g_chk
      a_fixed_prio: assert property (
         gnt[b] && !(|(elig[b] & port_hipri)) |-> (elig[b] & below(arb_idx[b])) == '0)
         else $error("lower-numbered port bypassed");
      a_port_count: assert property (
         q.start[b] |-> q.own[b] < q.ports)
         else $error("grant to an uninstalled port");
      a_hipri_wins: assert property (
         gnt[b] && (|(elig[b] & port_hipri)) |=> q.start[b] && port_hipri[q.own[b]])
         else $error("high-priority request not served first");
      a_full_time: assert property (
         q.start[b] && !(q.op_wr[b] && q.op_be[b] != `MCM_BE_ALL) |-> ##A_FULL bk_done[b])
         else $error("read or full write not 900 ns");
      a_part_time: assert property (
         q.start[b] && q.op_wr[b] && q.op_be[b] != `MCM_BE_ALL |-> ##A_PART bk_done[b])
         else $error("partial write not 1060 ns");
      a_range_hit: assert property (
         gnt[b] |-> hit[arb_idx[b]] && bsel[arb_idx[b]] == b)
         else $error("grant outside unit range or bank");
      a_mod2_map: assert property (
         gnt[b] && ilv == MCM_ILV_MOD2 |-> port_addr[arb_idx[b]][`MCM_ILV_ABIT] == b)
         else $error("modulo-2 bank select wrong");
      a_bank_hold: assert property (
         bk_busy[b] |-> $stable(q.own[b]) && !gnt[b])
         else $error("bank owner changed mid-operation");
      a_snap_cpu: assert property (
         q.start[b] && q.op_snap[b] |-> q.op_cpu[b] && !q.op_wr[b])
         else $error("snapshot access by non-CPU");
   end

   a_bank_parallel: assert property (
      bk_busy[0] && !bk_done[0] && gnt[1] |=> q.start[1] && bk_busy[0])
      else $error("bank 1 blocked by busy bank 0");
   a_trap_cpu: assert property (
      (q.trap & ~(q.ack & port_cpu)) == '0)
      else $error("trap to a non-CPU or without ack");
   a_byte_zero: assert property (
      q.ack[0] && port_size[0] == MCM_SZ_BYTE |-> q.prd[0][`MCM_DW-1:`MCM_BYTE] == '0)
      else $error("byte read upper bits not zero");
   a_bus_answer: assert property (
      (avs_read || avs_write) && q.wt |=> !q.wt ##1 q.wt)
      else $error("waitrequest answer not one cycle");

   c_both_busy: cover property (bk_busy[0] && bk_busy[1]);
   c_hipri: cover property (q.status[`MCM_ST_HIPRI]);
   c_trap: cover property (|q.trap);
   c_diag_read: cover property (q.start[0] && q.op_snap[0]);
endmodule : mcm_unit

// File: bench/mcm_port_model.sv
// Model of the processors standing on the memory ports.
// Assumes issue is called just after a rising edge of clk_sys.
`timescale 1ns/100ps
`include "mcm_regs.svh"
module mcm_port_model
   import mcm_pkg::*;
(
   input  wire logic                               clk_sys,
   input  wire logic [`MCM_NPORT-1:0]              ack,
   output      logic [`MCM_NPORT-1:0]              req,
   output      logic [`MCM_NPORT-1:0]              hi,
   output      logic [`MCM_NPORT-1:0]              cpu,
   output      logic [`MCM_NPORT-1:0]              wr,
   output      logic [`MCM_NPORT-1:0][1:0]         sz,
   output      logic [`MCM_NPORT-1:0][1:0]         bo,
   output      logic [`MCM_NPORT-1:0][`MCM_AW-1:0] ad,
   output      logic [`MCM_NPORT-1:0][`MCM_DW-1:0] wd
);
   initial begin
      {req, hi, wr, sz, bo, ad, wd} = '0;
      cpu = '1;
   end
   task issue(input int p, input logic [21:0] a, input logic w, input logic [31:0] d,
              input logic [1:0] s, input logic [1:0] b, input logic h);
      hi[p]  <= h;
      wr[p]  <= w;
      sz[p]  <= s;
      bo[p]  <= b;
      ad[p]  <= a;
      wd[p]  <= d;
      req[p] <= 1'b1;
   endtask : issue
   // Hold until ack, then drop and scramble data
   always @(posedge clk_sys) begin
      foreach (ack[i]) begin
         if (ack[i] === 1'b1) begin
            req[i] <= 1'b0;
            hi[i]  <= 1'b0;
            wd[i]  <= ~wd[i];
         end
      end
   end
endmodule : mcm_port_model

// File: bench/mcm_unit_bench.sv
// Bench for the memory unit: register bus tasks and port sequences.
// Assumes the port model file is compiled first.
`timescale 1ns/100ps
module mcm_unit_bench;
   import mcm_pkg::*;
   logic clk_sys, rst_n, rd_s, wr_s, wt, irq;
   logic [4:0] adr;
   logic [31:0] wdat, rdat, rd;
   logic [11:0] req, hi, cpu, wr, ack, trap, seen, tr, dg, sn;
   logic [11:0][1:0] sz, bo;
   logic [11:0][21:0] ad;
   logic [11:0][31:0] wd, prd;
   int error_cnt = 0, checked = 0, n;
   mcm_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_s),
      .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
      .avs_waitrequest(wt), .irq(irq), .port_req(req), .port_hipri(hi), .port_cpu(cpu),
      .port_write(wr), .port_diag(dg), .port_snap(sn), .port_size(sz),
      .port_boff(bo), .port_addr(ad), .port_wdata(wd), .port_ack(ack), .port_rdata(prd),
      .port_trap(trap));
   mcm_port_model pm (.clk_sys(clk_sys), .ack(ack), .req(req), .hi(hi), .cpu(cpu),
      .wr(wr), .sz(sz), .bo(bo), .ad(ad), .wd(wd));
   task report_and_stop;
      if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   task chk(input string s, input logic [31:0] e, input logic [31:0] v);
      checked++;
      if (v !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", s, e, v);
      end
   endtask : chk
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      adr  <= a;
      wdat <= d;
      wr_s <= w;
      rd_s <= !w;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (wt === 1'b0) break;
      end
      rd = rdat;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      chk("bus answer", 0, n == 20);
      if (n == 20) report_and_stop();
   endtask : bus
   task wack(input int p);
      seen = '0;
      tr   = '0;
      for (n = 1; n < 300; n++) begin
         @(negedge clk_sys);
         seen = seen | ack;
         tr   = tr | trap;
         if (ack[p] === 1'b1) break;
      end
      if (n == 300) begin
         error_cnt++;
         report_and_stop();
      end
      @(posedge clk_sys);
   endtask : wack
   initial begin
      clk_sys = 0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      {rst_n, rd_s, wr_s, adr, wdat, dg, sn} = '0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      bus(0, 5'h00, 0); chk("ctrl", 32'h1, rd);
      bus(0, 5'h10, 0); chk("ports", 32'hC, rd);
      bus(0, 5'h02, 0); chk("unmapped", 0, rd);
      bus(1, 5'h0C, 32'h4);
      @(posedge clk_sys); pm.issue(0, 2, 1, 32'hCAFE_F00D, 2, 0, 0);
      wack(0); chk("full cyc", 184, n);
      @(posedge clk_sys); pm.issue(1, 2, 1, 32'hA5, 0, 1, 0);
      wack(1); chk("part cyc", 216, n);
      @(posedge clk_sys); pm.issue(1, 2, 0, 0, 2, 0, 0);
      wack(1); chk("word", 32'hCAFE_A50D, prd[1]);
      @(posedge clk_sys); pm.issue(2, 2, 0, 0, 1, 2, 0);
      wack(2); chk("half", 32'hCAFE, prd[2]);
      @(posedge clk_sys); pm.issue(2, 4, 0, 0, 2, 0, 0); pm.issue(1, 4, 0, 0, 2, 0, 0);
      wack(1); chk("low wins", 0, seen[2]);
      wack(2);
      @(posedge clk_sys); pm.issue(1, 4, 0, 0, 2, 0, 0); pm.issue(3, 4, 0, 0, 2, 0, 1);
      wack(3); chk("hipri", 0, seen[1]);
      chk("irq set", 1, irq);
      bus(0, 5'h08, 0); chk("status", 32'h4, rd);
      wack(1); chk("irq clr", 0, irq);
      @(posedge clk_sys);
      pm.issue(0, 6, 0, 0, 2, 0, 0);
      // Second bank asked while the first is already busy
      repeat (2) @(posedge clk_sys);
      pm.issue(4, 7, 0, 0, 2, 0, 0);
      wack(0);
      wack(4);
      chk("both banks", 2, n);
      bus(1, 5'h00, 32'h9);
      @(posedge clk_sys);
      pm.issue(0, 8, 1, 32'h1234_5678, 2, 0, 0);
      wack(0);
      bus(1, 5'h00, 32'h1);
      @(posedge clk_sys);
      pm.issue(0, 8, 0, 0, 2, 0, 0);
      wack(0);
      chk("trap", 1, tr[0]);
      bus(0, 5'h08, 0);
      chk("cpu err", 32'h1, rd);
      @(posedge clk_sys);
      pm.issue(0, 8, 0, 0, 2, 0, 0);
      dg <= 12'h001;
      sn <= 12'h001;
      wack(0);
      dg <= '0;
      sn <= '0;
      chk("snap0", 32'h0000_0101, prd[0]);
      bus(0, 5'h18, 0);
      chk("snap1", 32'h0000_1001, rd);
      @(posedge clk_sys); pm.issue(5, 22'h8000, 0, 0, 2, 0, 0);
      repeat (250) @(negedge clk_sys) if (ack[5] !== 1'b0) chk("range", 0, 1);
      report_and_stop();
   end
endmodule : mcm_unit_bench
